// [shared/analog_map_pkg.sv]
package analog_map_pkg;

    // ------------------------------------------------------------
    // Register map (APB byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_RANGE   = 8'h00;
    localparam logic [7:0] ADDR_FUNC    = 8'h04;
    localparam logic [7:0] ADDR_START   = 8'h08;
    localparam logic [7:0] ADDR_END     = 8'h0c;
    localparam logic [7:0] ADDR_FILTER  = 8'h10;
    localparam logic [7:0] ADDR_SMOOTH  = 8'h14;
    localparam logic [7:0] ADDR_STATUS  = 8'h18;
    localparam logic [7:0] ADDR_CODE    = 8'h1c;
    localparam logic [7:0] ADDR_PINSEL  = 8'h20;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int          BEAM_W        = 8;
    localparam int          CODE_W        = 12;
    localparam logic [12:0] CODE_SPAN     = 13'h1000;
    localparam logic [2:0]  RANGE_RST     = 3'h0;
    localparam logic [2:0]  FUNC_RST      = 3'h0;
    localparam logic [7:0]  START_RST     = 8'h01;
    localparam logic [7:0]  END_RST       = 8'h20;
    localparam logic [7:0]  FILTER_RST    = 8'h01;
    localparam logic [7:0]  SMOOTH_RST    = 8'h01;
    localparam logic [1:0]  PINSEL_RST    = 2'h2;

    // Converter codes for range ends: 20 mA full scale of 24 mA, 4 mA start
    localparam logic [11:0] CODE_FULL     = 12'hfff;
    localparam logic [11:0] CODE_4MA_OF20 = 12'h333;
    localparam logic [11:0] CODE_20MA_24  = 12'hd55;
    localparam logic [11:0] CODE_5V_OF11  = 12'h745;
    localparam logic [11:0] CODE_10V_OF11 = 12'he8b;

    // ------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        RNG_OFF = 3'h0, RNG_V5 = 3'h1, RNG_V10 = 3'h2, RNG_V11 = 3'h3,
        RNG_MA4_20 = 3'h4, RNG_MA0_20 = 3'h5, RNG_MA0_24 = 3'h6
    } range_t;

    typedef enum logic [2:0] {
        FN_OFF = 3'h0,
        first_interrupted_beam = 3'h1, first_uninterrupted_beam = 3'h2,
        last_interrupted_beam = 3'h3, last_uninterrupted_beam = 3'h4,
        total_interrupted_beams = 3'h5, total_uninterrupted_beams = 3'h6
    } func_t;

    // Results of all evaluation functions for one measurement cycle
    typedef struct packed {
        logic [7:0] first_int;
        logic [7:0] first_free;
        logic [7:0] last_int;
        logic [7:0] last_free;
        logic [7:0] total_int;
        logic [7:0] total_free;
    } beam_result_t;

    // Converter output word
    typedef struct packed {
        logic        voltage;
        logic [11:0] code;
    } dac_word_t;

endpackage : analog_map_pkg

// [rtl/beam_to_analog_output_mapper.sv]
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/10ps

module beam_to_analog_output_mapper
    import analog_map_pkg::*;
#(
    parameter int NUM_BEAMS = 32
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Non-volatile storage: restore at power-up, save on change
    input  wire logic             nv_valid,
    input  wire logic [47:0]      nv_data,
    output logic                  nv_save,
    output logic      [47:0]      nv_wdata,
    // Local panel writes (same clock domain)
    input  wire logic             panel_we,
    input  wire logic [7:0]       panel_addr,
    input  wire logic [7:0]       panel_data,
    // Measurement cycle: beam state per cycle, interrupted = 1
    input  wire logic             meas_strobe,
    input  wire logic [NUM_BEAMS-1:0] beam_state,
    // Converter and pin assignment
    output dac_word_t             dac_out,
    output logic                  dac_load,
    output logic      [1:0]       pin_enable,
    output logic                  detect
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // Range end codes: minimum and maximum converter code per range
    function automatic logic [23:0] range_ends(input logic [2:0] r);
        case (r)
            RNG_V5:     range_ends = {12'h000, CODE_5V_OF11};
            RNG_V10:    range_ends = {12'h000, CODE_10V_OF11};
            RNG_V11:    range_ends = {12'h000, CODE_FULL};
            RNG_MA4_20: range_ends = {CODE_4MA_OF20, CODE_20MA_24};
            RNG_MA0_20: range_ends = {12'h000, CODE_20MA_24};
            RNG_MA0_24: range_ends = {12'h000, CODE_FULL};
            default:    range_ends = 24'h000000;
        endcase
    endfunction : range_ends

    // Low byte of a bus word
    function automatic logic [7:0] lo8(input logic [31:0] d);
        lo8 = d[7:0];
    endfunction : lo8

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [2:0] range_reg;
    logic [2:0] func_reg;
    logic [7:0] start_reg;
    logic [7:0] end_reg;
    logic [7:0] filter_reg;
    logic [7:0] smooth_reg;
    logic [1:0] pinsel_reg;
    logic       restored_reg;
    logic       cfg_dirty_reg;

    wire apb_wr = psel && penable && pwrite;
    wire apb_rd = psel && !penable && !pwrite;
    wire addr_ok = (paddr <= ADDR_PINSEL) && (paddr[1:0] == 2'b00);

    // Single writer: APB wins over panel only when both land together;
    // otherwise whichever arrives later simply overwrites
    wire       cfg_we   = apb_wr || panel_we;
    wire [7:0] cfg_addr = apb_wr ? paddr : panel_addr;
    wire [7:0] cfg_data = apb_wr ? lo8(pwdata) : panel_data;

    // Restore once from storage, then accept writes in arrival order
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            range_reg     <= RANGE_RST;
            func_reg      <= FUNC_RST;
            start_reg     <= START_RST;
            end_reg       <= END_RST;
            filter_reg    <= FILTER_RST;
            smooth_reg    <= SMOOTH_RST;
            pinsel_reg    <= PINSEL_RST;
            restored_reg  <= 1'b0;
        end else if (!restored_reg && nv_valid) begin
            range_reg     <= nv_data[42:40];
            func_reg      <= nv_data[34:32];
            start_reg     <= nv_data[31:24];
            end_reg       <= nv_data[23:16];
            filter_reg    <= nv_data[15:8];
            smooth_reg    <= nv_data[7:0];
            pinsel_reg    <= nv_data[45:44];
            restored_reg  <= 1'b1;
            // Restore beats a write in the same cycle
        end else if (cfg_we) begin
            if (cfg_addr == ADDR_RANGE) begin
                range_reg <= cfg_data[2:0];
            end else if (cfg_addr == ADDR_FUNC) begin
                func_reg <= cfg_data[2:0];
            end else if (cfg_addr == ADDR_START) begin
                start_reg <= cfg_data;
            end else if (cfg_addr == ADDR_END) begin
                end_reg <= cfg_data;
            end else if (cfg_addr == ADDR_FILTER) begin
                filter_reg <= cfg_data;
            end else if (cfg_addr == ADDR_SMOOTH) begin
                smooth_reg <= cfg_data;
            end else if (cfg_addr == ADDR_PINSEL) begin
                pinsel_reg <= cfg_data[1:0];
            end
        end
    end

    // Save request: one pulse two cycles after any change accepted once restored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_dirty_reg <= 1'b0;
            nv_save       <= 1'b0;
            nv_wdata      <= 48'h000000000000;
        end else begin
            // Only restored settings are saved
            cfg_dirty_reg <= cfg_we && restored_reg;
            nv_save       <= cfg_dirty_reg;
            nv_wdata      <= {2'b00, pinsel_reg, 1'b0, range_reg, 5'h00, func_reg,
                              start_reg, end_reg, filter_reg, smooth_reg};
        end
    end

    // ------------------------------------------------------------
    // Filter depth: count consistent measurement cycles
    // ------------------------------------------------------------
    logic [NUM_BEAMS-1:0] last_beams_reg;
    logic [NUM_BEAMS-1:0] stable_beams_reg;
    logic [7:0]           same_cnt_reg;
    logic                 eval_go_reg;
    // Nine bits: a saturated count must not wrap
    wire [8:0]            cnt_plus = {1'b0, same_cnt_reg} + 9'h001;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_beams_reg   <= '0;
            stable_beams_reg <= '0;
            same_cnt_reg     <= 8'h00;
            eval_go_reg      <= 1'b0;
        end else begin
            // One pulse per evaluation
            eval_go_reg <= 1'b0;
            if (meas_strobe) begin
                last_beams_reg <= beam_state;
                if (beam_state != last_beams_reg) begin
                    same_cnt_reg <= 8'h01;
                end else if (same_cnt_reg != 8'hff) begin
                    same_cnt_reg <= same_cnt_reg + 8'h01;
                end
                // Evaluate once the pattern has held for the filter depth
                if (beam_state == last_beams_reg && cnt_plus >= {1'b0, filter_reg}) begin
                    stable_beams_reg <= beam_state;
                    eval_go_reg      <= 1'b1;
                end else if (filter_reg <= 8'h01) begin
                    stable_beams_reg <= beam_state;
                    eval_go_reg      <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Evaluation functions over the stable pattern (beam 1 = bit 0)
    // ------------------------------------------------------------
    beam_result_t res;

    always_comb begin
        res = '0;
        // Scan down: first fields end lowest
        for (int i = NUM_BEAMS - 1; i >= 0; i--) begin
            if (stable_beams_reg[i]) begin
                res.first_int = 8'(i + 1);
            end else begin
                res.first_free = 8'(i + 1);
            end
        end
        // Scan up: last fields end highest
        for (int i = 0; i < NUM_BEAMS; i++) begin
            if (stable_beams_reg[i]) begin
                res.last_int  = 8'(i + 1);
                res.total_int = res.total_int + 8'h01;
            end else begin
                res.last_free  = 8'(i + 1);
                res.total_free = res.total_free + 8'h01;
            end
        end
    end

    // Smoothing: too few interrupted beams counts as nothing detected
    wire below_smooth = res.total_int < smooth_reg;

    logic [7:0] sel_val;

    always_comb begin
        case (func_reg)
            first_interrupted_beam:    sel_val = res.first_int;
            first_uninterrupted_beam:  sel_val = res.first_free;
            last_interrupted_beam:     sel_val = res.last_int;
            last_uninterrupted_beam:   sel_val = res.last_free;
            total_interrupted_beams:   sel_val = res.total_int;
            total_uninterrupted_beams: sel_val = res.total_free;
            default:                   sel_val = 8'h00;
        endcase
        // Too few beams report nothing
        if (below_smooth && func_reg != FN_OFF) begin
            sel_val = 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Characteristic curve
    // ------------------------------------------------------------
    wire        inverted = start_reg > end_reg;
    wire [7:0]  lo_beam  = inverted ? end_reg : start_reg;
    wire [7:0]  hi_beam  = inverted ? start_reg : end_reg;
    wire [8:0]  n_beams  = {1'b0, hi_beam} - {1'b0, lo_beam} + 9'h001;
    // Position within the area, clamped to 0 .. n_beams
    logic [8:0]  pos;
    logic [12:0] step;
    logic [21:0] frac;
    logic [23:0] ends;
    logic [11:0] span;
    logic [23:0] scaled;
    logic [11:0] code_next;

    always_comb begin
        if (sel_val < lo_beam) begin
            pos = 9'h000;
        end else if (sel_val >= hi_beam) begin
            pos = n_beams;
        end else begin
            pos = {1'b0, sel_val} - {1'b0, lo_beam} + 9'h001;
        end
        // Even step of the full span per beam gives the stepped curve
        step = CODE_SPAN / 13'(n_beams);
        frac = (pos == n_beams) ? {10'h000, CODE_FULL} : 22'(pos * step);
        if (inverted) begin
            frac = {10'h000, CODE_FULL} - frac;
        end
        ends   = range_ends(range_reg);
        // Unit curve scaled into the range
        span   = ends[11:0] - ends[23:12];
        scaled = 24'(frac[11:0] * span) / 24'h000fff;
        code_next = ends[23:12] + scaled[11:0];
        // Off parks the code at zero
        if (range_reg == RNG_OFF || func_reg == FN_OFF) begin
            code_next = 12'h000;
        end
    end

    // ------------------------------------------------------------
    // Converter output and pins: registered; output updated per evaluation, pins every cycle
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_out    <= '0;
            dac_load   <= 1'b0;
            pin_enable <= 2'b00;
            detect     <= 1'b0;
        end else begin
            dac_load <= eval_go_reg;
            // Off lands with the next load, never between
            if (eval_go_reg) begin
                dac_out.code    <= code_next;
                dac_out.voltage <= range_reg inside {RNG_V5, RNG_V10, RNG_V11};
                detect          <= !below_smooth;
            end
            // Off range releases both pins
            pin_enable <= (range_reg == RNG_OFF) ? 2'b00 : pinsel_reg;
        end
    end

    // ------------------------------------------------------------
    // APB read side: zero wait states, unmapped reads zero with error
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // Answer in the access phase
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            prdata  <= 32'h00000000;
            if (apb_rd) begin
                if (paddr == ADDR_RANGE) begin
                    prdata <= {29'h0, range_reg};
                end else if (paddr == ADDR_FUNC) begin
                    prdata <= {29'h0, func_reg};
                end else if (paddr == ADDR_START) begin
                    prdata <= {24'h0, start_reg};
                end else if (paddr == ADDR_END) begin
                    prdata <= {24'h0, end_reg};
                end else if (paddr == ADDR_FILTER) begin
                    prdata <= {24'h0, filter_reg};
                end else if (paddr == ADDR_SMOOTH) begin
                    prdata <= {24'h0, smooth_reg};
                end else if (paddr == ADDR_STATUS) begin
                    prdata <= {28'h0, restored_reg, inverted, detect, dac_load};
                end else if (paddr == ADDR_CODE) begin
                    prdata <= {19'h0, dac_out.voltage, dac_out.code};
                end else if (paddr == ADDR_PINSEL) begin
                    prdata <= {30'h0, pinsel_reg};
                end
            end
        end
    end

endmodule : beam_to_analog_output_mapper

// [tb/mapper_chk.sv]
`timescale 1ns/10ps
module mapper_chk
    import analog_map_pkg::*;
#(
    parameter int NUM_BEAMS = 32
) (
    // Clock, reset and APB
    input wire logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [7:0]           paddr,
    input wire logic [31:0]          pwdata, prdata,
    // Storage, panel, measurement and converter
    input wire logic                 nv_valid, nv_save, panel_we, meas_strobe, dac_load, detect,
    input wire logic [47:0]          nv_data, nv_wdata,
    input wire logic [7:0]           panel_addr, panel_data,
    input wire logic [NUM_BEAMS-1:0] beam_state,
    input wire dac_word_t            dac_out,
    input wire logic [1:0]           pin_enable
);
    // ----------------------------------------------------------
    // Port relations
    // ----------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // APB answers in the access phase right after setup, and only then
    property p_ready_next; psel && !penable |=> pready && psel && penable; endproperty
    a_ready_next: assert property (p_ready_next) else $error("pready late");
    property p_ready_only; pready |-> penable && $past(psel && !penable); endproperty
    a_ready_only: assert property (p_ready_only) else $error("stray pready");
    // Unmapped or misaligned places are refused and read as zero
    property p_err_bad;
        psel && !penable && (paddr > 8'h20 || paddr[1:0] != 2'h0) |=> pslverr;
    endproperty
    a_err_bad: assert property (p_err_bad) else $error("no pslverr");
    property p_err_zero; pslverr |-> pready && (pwrite || prdata == 32'h0); endproperty
    a_err_zero: assert property (p_err_zero) else $error("bad error reply");
    // A new evaluation lands two cycles after the strobe that qualified it
    property p_load_cause; dac_load |-> $past(meas_strobe, 2); endproperty
    a_load_cause: assert property (p_load_cause) else $error("load without strobe");
    // Output and detection hold between evaluations, so the controller sees a steady level
    property p_out_hold; !dac_load |-> $stable(dac_out); endproperty
    a_out_hold: assert property (p_out_hold) else $error("dac_out moved");
    property p_detect_hold; !dac_load |-> $stable(detect); endproperty
    a_detect_hold: assert property (p_detect_hold) else $error("detect moved");
    // Saving follows a configuration write from either source
    property p_save_cause;
        nv_save |-> $past(psel && penable && pwrite, 2) || $past(panel_we, 2);
    endproperty
    a_save_cause: assert property (p_save_cause) else $error("save without write");

    c_load: cover property (dac_load && detect);
    c_err: cover property (pslverr);
    c_save: cover property (nv_save);
endmodule : mapper_chk

bind beam_to_analog_output_mapper mapper_chk #(.NUM_BEAMS(NUM_BEAMS)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .nv_valid(nv_valid), .nv_save(nv_save), .panel_we(panel_we), .meas_strobe(meas_strobe),
    .dac_load(dac_load), .detect(detect), .nv_data(nv_data), .nv_wdata(nv_wdata),
    .panel_addr(panel_addr), .panel_data(panel_data), .beam_state(beam_state),
    .dac_out(dac_out), .pin_enable(pin_enable));

// [tb/plc_analog_input.sv]
`timescale 1ns/10ps
module plc_analog_input
    import analog_map_pkg::*;
#(
    parameter int HOLD = 8
) (
    // Clock, reset and converter word
    input  wire logic      pclk,
    input  wire logic      presetn,
    input  wire dac_word_t dac_out,
    // Accepted level
    output logic [11:0]    value,
    output logic           valid
);
    // ----------------------------------------------------------
    // Settling filter
    // ----------------------------------------------------------
    logic [11:0] last_reg;
    int          quiet_reg;

    // A full step needs time to settle, so only a level left alone is taken
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_reg  <= 12'h000;
            quiet_reg <= 0;
        end else if (dac_out.code != last_reg) begin
            last_reg  <= dac_out.code;
            quiet_reg <= 0;
        end else if (quiet_reg < HOLD) begin
            quiet_reg <= quiet_reg + 1;
        end
    end

    assign value = last_reg;
    assign valid = (quiet_reg >= HOLD);
endmodule : plc_analog_input

// [tb/tb_top.sv]
`timescale 1ns/10ps
module tb_top
    import analog_map_pkg::*;
;
    // ----------------------------------------------------------
    // Signals, expectations and instances
    // ----------------------------------------------------------
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        nv_valid = 1'b0, panel_we = 1'b0, meas_strobe = 1'b0;
    logic [7:0]  paddr = 8'h00, panel_addr = 8'h00, panel_data = 8'h00;
    logic [31:0] pwdata = 32'h0, beam_state = 32'h0, prdata, rd;
    logic [47:0] nv_data = 48'h2401_0120_0101, nv_wdata;
    logic        pready, pslverr, nv_save, dac_load, detect, err, ld, plc_valid;
    logic [1:0]  pin_enable;
    logic [11:0] plc_value, code_a;
    dac_word_t   dac_out;
    int          n_errors = 0, cmp_count = 0, cycles = 0;
    // Range ends by range code; index 0 (off) is handled apart
    logic [11:0] hi [1:6] = '{CODE_5V_OF11, CODE_10V_OF11, CODE_FULL, CODE_20MA_24,
                              CODE_20MA_24, CODE_FULL};
    logic [11:0] lo [1:6] = '{12'h000, 12'h000, 12'h000, CODE_4MA_OF20, 12'h000, 12'h000};
    // Pattern per function code that puts its result on beam 32
    logic [31:0] pat [7] = '{32'hffff_ffff, 32'h8000_0000, 32'h7fff_ffff, 32'hffff_ffff,
                             32'h0, 32'hffff_ffff, 32'h0};

    beam_to_analog_output_mapper #(.NUM_BEAMS(32)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .nv_valid(nv_valid), .nv_data(nv_data), .nv_save(nv_save), .nv_wdata(nv_wdata),
        .panel_we(panel_we), .panel_addr(panel_addr), .panel_data(panel_data),
        .meas_strobe(meas_strobe), .beam_state(beam_state), .dac_out(dac_out),
        .dac_load(dac_load), .pin_enable(pin_enable), .detect(detect));
    plc_analog_input #(.HOLD(8)) plc (.pclk(pclk), .presetn(presetn), .dac_out(dac_out),
        .value(plc_value), .valid(plc_valid));

    always #20 pclk = ~pclk;

    // Hang guard; the whole run needs well under two thousand cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            summarize();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // APB master: request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic cfg(input logic [2:0] r, input logic [2:0] f, input logic [7:0] s,
                       input logic [7:0] e);
        apb(1'b1, ADDR_RANGE, {29'h0, r});
        apb(1'b1, ADDR_FUNC, {29'h0, f});
        apb(1'b1, ADDR_START, {24'h0, s});
        apb(1'b1, ADDR_END, {24'h0, e});
    endtask : cfg

    // One measurement cycle; ld notes whether an evaluation was applied
    task automatic meas(input logic [31:0] p);
        @(posedge pclk);
        meas_strobe <= 1'b1;
        beam_state <= p;
        @(posedge pclk);
        meas_strobe <= 1'b0;
        ld = 1'b0;
        repeat (4) begin
            @(posedge pclk);
            if (dac_load === 1'b1) ld = 1'b1;
        end
    endtask : meas

    task automatic t_restore();
        apb(1'b0, ADDR_RANGE, 32'h0);
        check("range", rd, 32'h4);
        apb(1'b0, ADDR_END, 32'h0);
        check("end", rd, 32'h20);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check("restored", {31'h0, rd[3]}, 32'h1);
        apb(1'b0, 8'h24, 32'h0);
        check("bad_err", {31'h0, err}, 32'h1);
        check("bad_rd", rd, 32'h0);
        apb(1'b1, 8'h06, 32'h5);
        check("odd_err", {31'h0, err}, 32'h1);
    endtask : t_restore

    task automatic t_ranges();
        cfg(3'h1, 3'h3, 8'h01, 8'h20);
        for (int i = 1; i < 7; i++) begin
            apb(1'b1, ADDR_RANGE, i);
            meas(32'hffff_ffff);
            check("load", {31'h0, ld}, 32'h1);
            check("hi", {20'h0, dac_out.code}, {20'h0, hi[i]});
            check("volt", {31'h0, dac_out.voltage}, {31'h0, i < 4});
            meas(32'h0);
            check("lo", {20'h0, dac_out.code}, {20'h0, lo[i]});
            check("pins", {30'h0, pin_enable}, 32'h2);
        end
        apb(1'b1, ADDR_RANGE, 32'h0);
        meas(32'hffff_ffff);
        check("off", {20'h0, dac_out.code}, 32'h0);
        check("pins_off", {30'h0, pin_enable}, 32'h0);
    endtask : t_ranges

    task automatic t_funcs();
        apb(1'b1, ADDR_RANGE, 32'h6);
        apb(1'b1, ADDR_SMOOTH, 32'h0);
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, ADDR_FUNC, i);
            meas(pat[i]);
            check("func", {20'h0, dac_out.code}, (i == 0) ? 32'h0 : 32'hfff);
        end
    endtask : t_funcs

    task automatic t_window();
        cfg(3'h4, 3'h3, 8'h05, 8'h14);
        meas(32'h0100_0000);
        check("above", {20'h0, dac_out.code}, {20'h0, CODE_20MA_24});
        meas(32'h0000_0002);
        check("below", {20'h0, dac_out.code}, {20'h0, CODE_4MA_OF20});
        cfg(3'h6, 3'h3, 8'h01, 8'h04);
        meas(32'h3);
        code_a = dac_out.code;
        meas(32'h7);
        check("step", {20'h0, dac_out.code - code_a}, 32'h400);
    endtask : t_window

    task automatic t_invert();
        cfg(3'h4, 3'h3, 8'h20, 8'h01);
        meas(32'h0);
        check("inv_free", {20'h0, dac_out.code}, {20'h0, CODE_20MA_24});
        meas(32'hffff_ffff);
        check("inv_full", {20'h0, dac_out.code}, {20'h0, CODE_4MA_OF20});
        apb(1'b0, ADDR_STATUS, 32'h0);
        check("inv_flag", {31'h0, rd[2]}, 32'h1);
        repeat (12) @(posedge pclk);
        check("plc_ok", {31'h0, plc_valid}, 32'h1);
        check("plc_val", {20'h0, plc_value}, {20'h0, CODE_4MA_OF20});
    endtask : t_invert

    // Depth 3: the pattern change restarts the count
    task automatic t_filter_smooth();
        cfg(3'h4, 3'h3, 8'h01, 8'h20);
        apb(1'b1, ADDR_FILTER, 32'h3);
        for (int i = 0; i < 5; i++) begin
            meas((i < 2) ? 32'h1 : 32'h3);
            check("filter", {31'h0, ld}, {31'h0, i == 4});
        end
        apb(1'b1, ADDR_FILTER, 32'h1);
        apb(1'b1, ADDR_FUNC, 32'h5);
        apb(1'b1, ADDR_SMOOTH, 32'h4);
        meas(32'h7);
        check("det3", {31'h0, detect}, 32'h0);
        check("code3", {20'h0, dac_out.code}, {20'h0, CODE_4MA_OF20});
        meas(32'hf);
        check("det4", {31'h0, detect}, 32'h1);
    endtask : t_filter_smooth

    task automatic t_panel();
        apb(1'b1, ADDR_RANGE, 32'h2);
        @(posedge pclk);
        panel_we <= 1'b1;
        panel_addr <= ADDR_RANGE;
        panel_data <= 8'h06;
        @(posedge pclk);
        panel_we <= 1'b0;
        ld = 1'b0;
        repeat (4) begin
            @(posedge pclk);
            if (nv_save === 1'b1) ld = 1'b1;
        end
        check("saved", {31'h0, ld}, 32'h1);
        check("nv_range", {29'h0, nv_wdata[42:40]}, 32'h6);
        apb(1'b0, ADDR_RANGE, 32'h0);
        check("last_wins", rd, 32'h6);
    endtask : t_panel

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    // Stored settings are offered from the start, as after power-up
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        nv_valid <= 1'b1;
        t_restore();
        t_ranges();
        t_funcs();
        t_window();
        t_invert();
        t_filter_smooth();
        t_panel();
        summarize();
    end
endmodule : tb_top
